// ### core/spc_status_ctrl.v
/*
 Control fields and clear-on-read status of the speech conversion unit,
 reached over Avalon-MM with waitrequest.
 Assumes converter strobes are synchronous one-cycle pulses.
*/
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.vh"

module spc_status_ctrl #(
   parameter DEPTH = `SPC_FIFO_DEPTH
) (
   // Clock, reset, enable
   input  wire        core_clk_in,
   input  wire        sys_rst_in,
   input  wire        clk_en_in,
   // Avalon-MM slave
   input  wire [7:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   input  wire [3:0]  avs_byteenable_in,
   output reg  [31:0] avs_readdata_out,
   output reg         avs_waitrequest_out,
   // Converter events
   input  wire        freeze_in,
   input  wire        in_fifo_push_in,
   input  wire        in_fifo_pop_in,
   input  wire        out_fifo_push_in,
   input  wire        out_fifo_pop_in,
   input  wire        pcm_out_update_in,
   input  wire        pcm_in_consumed_in,
   // Requests and control
   output reg         level_irq_out,
   output reg         error_irq_out,
   output reg         pcm_irq_out,
   output reg         dma_pcm_in_req_out,
   output reg         dma_pcm_out_req_out,
   output reg         dma_delta_in_req_out,
   output reg         dma_delta_out_req_out,
   output reg  [1:0]  conv_format_out,
   output reg         law_select_out,
   output reg         conv_clk_enable_out
);

   reg  [15:0] speech_codec_control;
   reg         in_fifo_nearly_empty;
   reg         out_fifo_nearly_full;
   reg         pcm_service_flag;
   reg         in_fifo_underrun;
   reg         out_fifo_overflow;
   reg         pcm_out_full;
   reg         pcm_in_empty;
   reg  [15:0] linear_sample_in_buffer;
   reg  [15:0] linear_sample_out_buffer;
   reg  [15:0] atten_result;
   reg  [15:0] next_readdata;
   reg         ack;

   wire [3:0]  in_level;
   wire [3:0]  out_level;
   wire        in_underrun_evt;
   wire        out_overflow_evt;
   wire [15:0] expanded;
   wire [2:0]  in_fifo_free_count;
   wire [2:0]  out_fifo_valid_count;
   wire [15:0] speech_codec_status;
   wire        module_enable_bit;
   wire        near_empty_evt;
   wire        near_full_evt;
   wire        pcm_evt;
   wire        access;
   wire        status_read;
   wire        wr_ok;
   wire        in_pop_eff;
   wire        out_push_eff;

   // Saturating count, shared by both FIFO fields
   function [2:0] sat7;
      input [3:0] n;
      begin
         sat7 = (n > 4'h7) ? 3'h7 : n[2:0];
      end
   endfunction

   assign module_enable_bit = speech_codec_control[`SPC_CTL_ENABLE];
   // Freeze stops the converter side of both FIFOs
   assign in_pop_eff   = in_fifo_pop_in && !freeze_in;
   assign out_push_eff = out_fifo_push_in && !freeze_in;

   spc_fifo_level #(
      .DEPTH (DEPTH)
   ) u_in_fifo (
      .core_clk_in   (core_clk_in),
      .sys_rst_in    (sys_rst_in),
      .clk_en_in     (clk_en_in),
      .push_in       (in_fifo_push_in),
      .pop_in        (in_pop_eff),
      .level_out     (in_level),
      .pop_empty_out (in_underrun_evt),
      .push_full_out ()
   );

   spc_fifo_level #(
      .DEPTH (DEPTH)
   ) u_out_fifo (
      .core_clk_in   (core_clk_in),
      .sys_rst_in    (sys_rst_in),
      .clk_en_in     (clk_en_in),
      .push_in       (out_push_eff),
      .pop_in        (out_fifo_pop_in),
      .level_out     (out_level),
      .pop_empty_out (),
      .push_full_out (out_overflow_evt)
   );

   spc_expand u_expand (
      .sample_in  (linear_sample_in_buffer),
      .format_in  (speech_codec_control[`SPC_CTL_LAW] ?
                   `SPC_FMT_ALAW : `SPC_FMT_MULAW),
      .atten_in   (speech_codec_control[`SPC_CTL_ATTEN_LO+1:`SPC_CTL_ATTEN_LO]),
      .result_out (expanded)
   );

   assign in_fifo_free_count   = (in_level > 4'h6) ? 3'h0 :
                                 sat7(DEPTH[3:0] - in_level);
   assign out_fifo_valid_count = sat7(out_level);

   // Threshold crossings raise each level flag once
   assign near_empty_evt = in_pop_eff && ({28'h0, in_level} == `SPC_NEAR_LEVEL + 1)
                           && !in_fifo_push_in;
   assign near_full_evt  = out_push_eff && !out_fifo_pop_in &&
                           ({28'h0, out_level} == DEPTH - `SPC_NEAR_LEVEL - 1);
   assign pcm_evt = pcm_out_update_in || pcm_in_consumed_in;

   assign speech_codec_status = {5'h00, out_fifo_valid_count,
                                 in_fifo_free_count, out_fifo_overflow,
                                 in_fifo_underrun, pcm_service_flag,
                                 out_fifo_nearly_full,
                                 in_fifo_nearly_empty};

   assign access      = (avs_read_in || avs_write_in) && !ack;
   assign status_read = access && avs_read_in &&
                        (avs_address_in == `SPC_OFS_STATUS);
   // Only the control register stays writable while disabled
   assign wr_ok = access && avs_write_in &&
                  (module_enable_bit ||
                   avs_address_in == `SPC_OFS_CONTROL);

   // Read mux; unmapped and blocked addresses read zero
   always @* begin
      next_readdata = 16'h0000;
      if (avs_address_in == `SPC_OFS_CONTROL) begin
         next_readdata = speech_codec_control;
      end else if (!module_enable_bit) begin
         next_readdata = 16'h0000;
      end else if (avs_address_in == `SPC_OFS_STATUS) begin
         next_readdata = speech_codec_status;
      end else if (avs_address_in == `SPC_OFS_PCM_OUT) begin
         next_readdata = linear_sample_out_buffer;
      end else if (avs_address_in == `SPC_OFS_ATTEN_OUT) begin
         next_readdata = atten_result;
      end
   end

   // Bus handshake: one wait cycle, answer on the second edge
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ack                 <= 1'b0;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0000_0000;
      end else if (clk_en_in) begin
         ack                 <= access;
         avs_waitrequest_out <= !access;
         if (access && avs_read_in) begin
            avs_readdata_out <= {16'h0000, next_readdata};
         end
      end
   end

   // Control register and sample buffers
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         speech_codec_control     <= `SPC_CTL_RESET;
         linear_sample_in_buffer  <= 16'h0000;
         linear_sample_out_buffer <= 16'h0000;
         atten_result             <= 16'h0000;
         pcm_in_empty             <= 1'b0;
         pcm_out_full             <= 1'b0;
      end else if (clk_en_in) begin
         atten_result <= expanded;
         if (pcm_in_consumed_in) begin
            pcm_in_empty <= 1'b1;
         end
         if (pcm_out_update_in && !freeze_in) begin
            pcm_out_full             <= 1'b1;
            linear_sample_out_buffer <= linear_sample_out_buffer + 16'h0001;
         end
         if (wr_ok && avs_address_in == `SPC_OFS_CONTROL) begin
            if (avs_byteenable_in[0]) begin
               speech_codec_control[7:0] <= avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1]) begin
               speech_codec_control[15:8] <= avs_writedata_in[15:8] &
                                             8'h3F; // Bits 15:14 read 0
            end
         end else if (wr_ok && avs_address_in == `SPC_OFS_PCM_IN) begin
            linear_sample_in_buffer <= avs_writedata_in[15:0];
            pcm_in_empty            <= pcm_in_consumed_in; // Set wins
         end else if (access && avs_read_in && module_enable_bit &&
                      avs_address_in == `SPC_OFS_PCM_OUT &&
                      !pcm_out_update_in) begin
            pcm_out_full <= 1'b0;
         end
      end
   end

   // Sticky flags: set wins over clear-on-read
   always @(posedge core_clk_in) begin
      if (sys_rst_in || (clk_en_in && !module_enable_bit)) begin
         in_fifo_nearly_empty <= 1'b0;
         out_fifo_nearly_full <= 1'b0;
         pcm_service_flag     <= 1'b0;
         in_fifo_underrun     <= 1'b0;
         out_fifo_overflow    <= 1'b0;
      end else if (clk_en_in) begin
         if (near_empty_evt) begin
            in_fifo_nearly_empty <= 1'b1;
         end else if (status_read) begin
            in_fifo_nearly_empty <= 1'b0;
         end
         if (near_full_evt) begin
            out_fifo_nearly_full <= 1'b1;
         end else if (status_read) begin
            out_fifo_nearly_full <= 1'b0;
         end
         if (pcm_evt) begin
            pcm_service_flag <= 1'b1;
         end else if (status_read && !freeze_in) begin
            pcm_service_flag <= 1'b0;
         end
         if (in_underrun_evt) begin
            in_fifo_underrun <= 1'b1;
         end else if (status_read && !freeze_in) begin
            in_fifo_underrun <= 1'b0;
         end
         if (out_overflow_evt) begin
            out_fifo_overflow <= 1'b1;
         end else if (status_read && !freeze_in) begin
            out_fifo_overflow <= 1'b0;
         end
      end
   end

   // Requests follow flags and enables, registered
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         level_irq_out         <= 1'b0;
         error_irq_out         <= 1'b0;
         pcm_irq_out           <= 1'b0;
         dma_pcm_in_req_out    <= 1'b0;
         dma_pcm_out_req_out   <= 1'b0;
         dma_delta_in_req_out  <= 1'b0;
         dma_delta_out_req_out <= 1'b0;
         conv_format_out       <= 2'h0;
         law_select_out        <= 1'b0;
         conv_clk_enable_out   <= 1'b0;
      end else if (clk_en_in) begin
         level_irq_out <= speech_codec_control[`SPC_CTL_LEVEL_IRQ] &&
                          (in_fifo_nearly_empty ||
                           out_fifo_nearly_full);
         error_irq_out <= speech_codec_control[`SPC_CTL_ERROR_IRQ] &&
                          (in_fifo_underrun || out_fifo_overflow);
         pcm_irq_out   <= speech_codec_control[`SPC_CTL_PCM_IRQ] &&
                          pcm_service_flag;
         dma_pcm_in_req_out  <= module_enable_bit &&
                                speech_codec_control[`SPC_CTL_DMA_PIN] &&
                                pcm_in_empty;
         dma_pcm_out_req_out <= module_enable_bit &&
                                speech_codec_control[`SPC_CTL_DMA_POUT] &&
                                pcm_out_full;
         dma_delta_in_req_out  <= speech_codec_control[`SPC_CTL_DMA_DIN] &&
                                  in_fifo_nearly_empty;
         dma_delta_out_req_out <= speech_codec_control[`SPC_CTL_DMA_DOUT] &&
                                  out_fifo_nearly_full;
         conv_format_out <= speech_codec_control[`SPC_CTL_DCONV_LO+1:
                                                 `SPC_CTL_DCONV_LO];
         law_select_out  <= speech_codec_control[`SPC_CTL_LAW];
         conv_clk_enable_out <= speech_codec_control[`SPC_CTL_CLK_ENABLE];
      end
   end

endmodule // spc_status_ctrl

`default_nettype wire

// ### inc/spc_defs.vh
/*
 Register offsets, field positions, reset values and fixed counts of the
 speech codec control and status block.
 Assumes a 32-bit Avalon-MM slave with word addresses given as byte offsets.
*/
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// Byte offsets on the Avalon bus
`define SPC_OFS_CONTROL      8'h00
`define SPC_OFS_STATUS       8'h04
`define SPC_OFS_PCM_IN       8'h08
`define SPC_OFS_PCM_OUT      8'h0C
`define SPC_OFS_ATTEN_OUT    8'h10

// Control register fields
`define SPC_CTL_ENABLE       0
`define SPC_CTL_CLK_ENABLE   1
`define SPC_CTL_PCM_IRQ      2
`define SPC_CTL_LEVEL_IRQ    3
`define SPC_CTL_ERROR_IRQ    4
`define SPC_CTL_DMA_DOUT     5
`define SPC_CTL_DMA_DIN      6
`define SPC_CTL_DMA_POUT     7
`define SPC_CTL_DMA_PIN      8
`define SPC_CTL_DCONV_LO     9
`define SPC_CTL_LAW          11
`define SPC_CTL_ATTEN_LO     12
`define SPC_CTL_MASK         16'h3FFF
`define SPC_CTL_RESET        16'h0000

// Status register fields
`define SPC_ST_NEAR_EMPTY    0
`define SPC_ST_NEAR_FULL     1
`define SPC_ST_PCM_SERVICE   2
`define SPC_ST_UNDERRUN      3
`define SPC_ST_OVERFLOW      4
`define SPC_ST_RESET         16'h0000

// Conversion format codes
`define SPC_FMT_MULAW        2'h0
`define SPC_FMT_ALAW         2'h1
`define SPC_FMT_LINEAR       2'h2

// FIFO thresholds
`define SPC_FIFO_DEPTH       8
`define SPC_NEAR_LEVEL       3

`endif

// ### core/spc_fifo_level.v
/*
 Occupancy tracker for one eight-word converter FIFO, with error strobes.
 Assumes push and pop strobes are synchronous single-cycle events.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.vh"

module spc_fifo_level #(
   parameter DEPTH = `SPC_FIFO_DEPTH
) (
   // Clock and reset
   input  wire       core_clk_in,
   input  wire       sys_rst_in,
   input  wire       clk_en_in,
   // Strobes
   input  wire       push_in,
   input  wire       pop_in,
   // State
   output reg  [3:0] level_out,
   output wire       pop_empty_out,
   output wire       push_full_out
);

   wire do_push;
   wire do_pop;

   // Error strobes never move the level
   assign pop_empty_out = pop_in && (level_out == 4'h0);
   assign push_full_out = push_in && (level_out == DEPTH[3:0]);
   assign do_push       = push_in && !push_full_out;
   assign do_pop        = pop_in && !pop_empty_out;

   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         level_out <= 4'h0;
      end else if (clk_en_in) begin
         if (do_push && !do_pop) begin
            level_out <= level_out + 4'h1;
         end else if (do_pop && !do_push) begin
            level_out <= level_out - 4'h1;
         end
      end
   end

endmodule // spc_fifo_level

`default_nettype wire

// ### core/spc_expand.v
/*
 Expands a log PCM byte to a left-justified linear word, then attenuates.
 Assumes the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.vh"

module spc_expand (
   // Sample
   input  wire [15:0] sample_in,
   input  wire [1:0]  format_in,
   input  wire [1:0]  atten_in,
   // Result
   output wire [15:0] result_out
);

   reg  [15:0] linear;
   reg  [12:0] mag13;
   reg  [13:0] mag14;
   reg  [7:0]  code;
   reg  [2:0]  seg;
   reg  [3:0]  mant;

   always @* begin
      code   = 8'h00;
      seg    = 3'h0;
      mant   = 4'h0;
      mag13  = 13'h0000;
      mag14  = 14'h0000;
      linear = sample_in;
      if (format_in == `SPC_FMT_ALAW) begin
         code  = sample_in[7:0] ^ 8'h55;
         seg   = code[6:4];
         mant  = code[3:0];
         mag13 = (seg == 3'h0) ? {8'h00, mant, 1'b1} :
                 ({7'h00, 1'b1, mant, 1'b1} << (seg - 3'h1));
         // 13-bit value left-justified and zero-filled
         linear = {(code[7] ? mag13 : -mag13), 3'h0};
      end else if (format_in == `SPC_FMT_MULAW) begin
         code  = ~sample_in[7:0];
         seg   = code[6:4];
         mant  = code[3:0];
         mag14 = ({8'h00, 1'b1, mant, 1'b1} << seg) - 14'h0021;
         // 14-bit value left-justified and zero-filled
         linear = {(code[7] ? -mag14 : mag14), 2'h0};
      end
   end

   // Arithmetic shift keeps the sign
   assign result_out = $signed(linear) >>> atten_in;

endmodule // spc_expand

`default_nettype wire

// ### sim/spc_status_checker.sv
/*
 Concurrent checks on the speech codec control and status ports.
 Assumes one clock domain and an Avalon master that holds its request.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.vh"

module spc_status_checker #(
   parameter DEPTH = 8
) (
   // Clock and reset
   input wire logic        core_clk_in,
   input wire logic        sys_rst_in,
   input wire logic        clk_en_in,
   // Avalon-MM
   input wire logic [7:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   // Requests and control
   input wire logic        level_irq_out,
   input wire logic        error_irq_out,
   input wire logic        dma_pcm_in_req_out,
   input wire logic        dma_delta_in_req_out,
   input wire logic        dma_delta_out_req_out,
   input wire logic [1:0]  conv_format_out,
   input wire logic        law_select_out
);
   // Control shadow kept three deep, so gates tolerate output latency
   logic [15:0] ctl_q;
   logic [15:0] ctl_d1;
   logic [15:0] ctl_d2;
   wire  [15:0] ctl_any = ctl_q | ctl_d1 | ctl_d2;
   wire         ack     = clk_en_in && !avs_waitrequest_out;
   wire         ctl_ack = ack && avs_write_in &&
                          avs_address_in == `SPC_OFS_CONTROL;

   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ctl_q  <= 16'h0000;
         ctl_d1 <= 16'h0000;
         ctl_d2 <= 16'h0000;
      end else begin
         if (ctl_ack && avs_byteenable_in[0])
            ctl_q[7:0] <= avs_writedata_in[7:0];
         if (ctl_ack && avs_byteenable_in[1])
            ctl_q[15:8] <= avs_writedata_in[15:8] & 8'h3F;
         ctl_d1 <= ctl_q;
         ctl_d2 <= ctl_d1;
      end
   end

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_taken;
      clk_en_in && (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence s_st_ack;
      ack && avs_read_in && avs_address_in == `SPC_OFS_STATUS;
   endsequence
   sequence s_ctl_ack;
      ctl_ack;
   endsequence

   AST_ANSWER_NEXT: assert property (s_taken |=> !avs_waitrequest_out)
      else $error("waitrequest not low one cycle after request");
   AST_ANSWER_PULSE: assert property (ack |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   AST_STATUS_OFF: assert property (s_st_ack ##0 !ctl_any[0] |->
      avs_readdata_out == 32'h0000_0000)
      else $error("status not zero while disabled");
   AST_RSV_ZERO: assert property (s_st_ack |->
      avs_readdata_out[31:11] == 21'h000000)
      else $error("reserved status bits not zero");
   AST_FMT_COPY: assert property (s_ctl_ack |->
      ##2 conv_format_out == ctl_q[10:9])
      else $error("conversion format does not follow control");
   AST_LAW_COPY: assert property (s_ctl_ack |->
      ##2 law_select_out == ctl_q[11])
      else $error("law select does not follow control");
   AST_PIN_DMA: assert property (dma_pcm_in_req_out |-> ctl_any[8])
      else $error("pcm input dma request while disabled");
   AST_DIN_DMA: assert property (dma_delta_in_req_out |-> ctl_any[6])
      else $error("delta input dma request while disabled");
   AST_DOUT_DMA: assert property (dma_delta_out_req_out |-> ctl_any[5])
      else $error("delta output dma request while disabled");
   AST_LVL_IRQ: assert property (level_irq_out |-> ctl_any[3])
      else $error("level interrupt while masked");
   AST_ERR_IRQ: assert property (error_irq_out |-> ctl_any[4])
      else $error("error interrupt while masked");
endmodule // spc_status_checker

bind spc_status_ctrl spc_status_checker #(.DEPTH(DEPTH))
   spc_status_checker_i (.core_clk_in, .sys_rst_in, .clk_en_in,
   .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
   .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
   .level_irq_out, .error_irq_out, .dma_pcm_in_req_out,
   .dma_delta_in_req_out, .dma_delta_out_req_out, .conv_format_out,
   .law_select_out);

`default_nettype wire

// ### sim/spc_host_model.sv
/*
 Processor side of the peripheral bus: Avalon-MM master tasks.
 Assumes a slave that answers with one low cycle of waitrequest.
*/
`timescale 1ns/1ps
`default_nettype none

module spc_host_model (
   // Clock
   input  wire logic        core_clk_in,
   // Slave answer
   input  wire logic [31:0] avs_readdata_in,
   input  wire logic        avs_waitrequest_in,
   // Request
   output var  logic [7:0]  avs_address_out,
   output var  logic        avs_read_out,
   output var  logic        avs_write_out,
   output var  logic [31:0] avs_writedata_out,
   output var  logic [3:0]  avs_byteenable_out
);
   initial begin
      avs_address_out = 8'h00;
      avs_read_out = 1'b0;
      avs_write_out = 1'b0;
      avs_writedata_out = 32'h0000_0000;
      avs_byteenable_out = 4'hF;
   end

   task automatic bus_write(input logic [7:0] a, input logic [15:0] v);
      @(posedge core_clk_in);
      avs_address_out <= a;
      avs_writedata_out <= {16'h0000, v};
      avs_write_out <= 1'b1;
      do @(posedge core_clk_in); while (avs_waitrequest_in !== 1'b0);
      avs_write_out <= 1'b0;
      // Stale data is scrambled so the slave cannot lean on it
      avs_writedata_out <= ~avs_writedata_out;
   endtask

   task automatic bus_read(input logic [7:0] a, output logic [15:0] v);
      @(posedge core_clk_in);
      avs_address_out <= a;
      avs_read_out <= 1'b1;
      do @(posedge core_clk_in); while (avs_waitrequest_in !== 1'b0);
      v = avs_readdata_in[15:0];
      avs_read_out <= 1'b0;
   endtask
endmodule // spc_host_model

`default_nettype wire

// ### sim/spc_status_ctrl_tb.sv
/*
 Self-checking bench for the speech codec control and status block.
 Assumes the host model above and pulse strobes for converter events.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spc_defs.vh"

module spc_status_ctrl_tb;
   logic        clk;
   logic        rst;
   logic        frz;
   logic        ce;
   logic [5:0]  ev;
   logic [15:0] d;
   logic [15:0] v;
   int          mismatches;
   int          tests_run;
   int          cycles;
   wire  [7:0]  adr;
   wire         rd;
   wire         wr;
   wire  [31:0] wd;
   wire  [3:0]  be;
   wire  [31:0] rdat;
   wire         wreq;
   wire         lvl_irq;
   wire         err_irq;
   wire         pcm_irq;
   wire         dma_pin;
   wire         dma_pout;
   wire         clken;
   wire         dma_din;
   wire         dma_dout;
   wire  [1:0]  fmt;
   wire         law;
   logic [15:0] xc [3] = '{16'h3801, 16'h1001, 16'h0801};
   logic [15:0] xb [3] = '{16'h0055, 16'h0000, 16'h00D5};
   logic [15:0] xe [3] = '{16'hFFFF, 16'hC142, 16'h0008};

   spc_host_model spc_host_model_i (.core_clk_in(clk),
      .avs_readdata_in(rdat), .avs_waitrequest_in(wreq),
      .avs_address_out(adr), .avs_read_out(rd), .avs_write_out(wr),
      .avs_writedata_out(wd), .avs_byteenable_out(be));

   spc_status_ctrl #(.DEPTH(8)) spc_status_ctrl_i (.core_clk_in(clk),
      .sys_rst_in(rst), .clk_en_in(ce), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_byteenable_in(be), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wreq), .freeze_in(frz),
      .in_fifo_push_in(ev[0]), .in_fifo_pop_in(ev[1]),
      .out_fifo_push_in(ev[2]), .out_fifo_pop_in(ev[3]),
      .pcm_out_update_in(ev[4]), .pcm_in_consumed_in(ev[5]),
      .level_irq_out(lvl_irq), .error_irq_out(err_irq),
      .pcm_irq_out(pcm_irq), .dma_pcm_in_req_out(dma_pin),
      .dma_pcm_out_req_out(dma_pout), .dma_delta_in_req_out(dma_din),
      .dma_delta_out_req_out(dma_dout), .conv_format_out(fmt),
      .law_select_out(law), .conv_clk_enable_out(clken));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] g;
      spc_host_model_i.bus_read(a, g);
      chk($sformatf("register %h", a), e, g);
   endtask

   task automatic wc(input logic [7:0] a, input logic [15:0] x);
      spc_host_model_i.bus_write(a, x);
   endtask

   // Each strobe is one cycle wide with a gap, as the converter makes them
   task automatic pulse(input logic [5:0] m, input int n);
      repeat (n) begin
         @(posedge clk);
         ev <= m;
         @(posedge clk);
         ev <= 6'h00;
      end
   endtask

   task automatic idle;
      repeat (3) @(posedge clk);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up;
      end
   end

   initial begin
      rst = 1'b1;
      frz = 1'b0;
      ce = 1'b1;
      ev = 6'h00;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rc(`SPC_OFS_CONTROL, 16'h0000);
      rc(`SPC_OFS_STATUS, 16'h0000);
      pulse(6'h02, 1);
      rc(`SPC_OFS_STATUS, 16'h0000);
      wc(`SPC_OFS_CONTROL, 16'h001F);
      rc(`SPC_OFS_STATUS, 16'h00E0);
      chk("clock enable", 16'h0001, {15'h0000, clken});
      wc(`SPC_OFS_STATUS, 16'hFFFF);
      rc(`SPC_OFS_STATUS, 16'h00E0);
      // A push while the clock enable is low must not count
      ce <= 1'b0;
      pulse(6'h01, 1);
      ce <= 1'b1;
      pulse(6'h01, 4);
      pulse(6'h02, 1);
      idle;
      chk("level irq", 16'h0001, {15'h0000, lvl_irq});
      rc(`SPC_OFS_STATUS, 16'h00A1);
      rc(`SPC_OFS_STATUS, 16'h00A0);
      pulse(6'h02, 4);
      pulse(6'h10, 1);
      idle;
      chk("error irq", 16'h0001, {15'h0000, err_irq});
      chk("pcm irq", 16'h0001, {15'h0000, pcm_irq});
      frz <= 1'b1;
      rc(`SPC_OFS_STATUS, 16'h00EC);
      rc(`SPC_OFS_STATUS, 16'h00EC);
      frz <= 1'b0;
      rc(`SPC_OFS_STATUS, 16'h00EC);
      rc(`SPC_OFS_STATUS, 16'h00E0);
      pulse(6'h04, 5);
      rc(`SPC_OFS_STATUS, 16'h05E2);
      pulse(6'h04, 2);
      rc(`SPC_OFS_STATUS, 16'h07E0);
      pulse(6'h04, 1);
      rc(`SPC_OFS_STATUS, 16'h07E0);
      pulse(6'h04, 1);
      rc(`SPC_OFS_STATUS, 16'h07F0);
      rc(`SPC_OFS_STATUS, 16'h07E0);
      pulse(6'h01, 7);
      rc(`SPC_OFS_STATUS, 16'h0700);
      pulse(6'h01, 1);
      fork
         spc_host_model_i.bus_read(`SPC_OFS_STATUS, d);
         pulse(6'h10, 1);
      join
      rc(`SPC_OFS_STATUS, 16'h0704);
      wc(`SPC_OFS_CONTROL, 16'h01E1);
      pulse(6'h20, 1);
      idle;
      chk("pcm in dma", 16'h0001, {15'h0000, dma_pin});
      chk("pcm out dma", 16'h0001, {15'h0000, dma_pout});
      rc(`SPC_OFS_PCM_OUT, 16'h0002);
      wc(`SPC_OFS_PCM_IN, 16'h1234);
      idle;
      chk("pcm in dma", 16'h0000, {15'h0000, dma_pin});
      chk("pcm out dma", 16'h0000, {15'h0000, dma_pout});
      pulse(6'h02, 5);
      pulse(6'h08, 4);
      pulse(6'h04, 1);
      idle;
      chk("delta in dma", 16'h0001, {15'h0000, dma_din});
      chk("delta out dma", 16'h0001, {15'h0000, dma_dout});
      for (int k = 0; k < 4; k++) begin
         v = {5'h00, k[1:0], 9'h001};
         wc(`SPC_OFS_CONTROL, v);
         rc(`SPC_OFS_CONTROL, v);
         chk("format", {14'h0000, k[1:0]}, fmt);
      end
      for (int i = 0; i < 3; i++) begin
         wc(`SPC_OFS_CONTROL, xc[i]);
         wc(`SPC_OFS_PCM_IN, xb[i]);
         rc(`SPC_OFS_ATTEN_OUT, xe[i]);
         chk("law", {15'h0000, xc[i][11]}, law);
      end
      rc(8'h20, 16'h0000);
      wc(`SPC_OFS_CONTROL, 16'h0000);
      rc(`SPC_OFS_STATUS, 16'h0000);
      wrap_up;
   end
endmodule // spc_status_ctrl_tb

`default_nettype wire
